// file: logic/dpm_pin_mux.v
// Diagnostic pin mode mux: multifunction pins, probes, clock pin and user I/O
// What this block does
// - With the mode pin high, clock, serial input and both probe pins take diagnostic roles.
// - With the mode pin low, those four pins are ordinary user I/Os.
// - Each probe output shows its selected internal node, registered one cycle late.
// - A one-way fuse turns off probing on both probe pins until the next reset.
// - The diagnostic clock clocks probe selection, only while mode is high.
// - The serial input carries select data, only while mode is high.
// - The global clock input is buffered before reaching the logic.
// - The global clock pin may serve as a user I/O instead.
// - Each user I/O is input, output, three-state or bidirectional.
// - Unused user I/Os drive low.
// - After debugging, probe pins may be reused as user I/Os.
// - Once the security fuse is set, diagnostic access is refused until the next reset.
// - Probe pins as user I/Os behave like all other user I/Os.
`include "dpm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module dpm_pin_mux (
   input wire sys_clk_i,
   input wire rst_i,
   input wire clk_en_i,
   input wire mode_i,
   input wire [`DPM_NPINS-1:0] pad_i,
   output wire [`DPM_NPINS-1:0] pad_o,
   output wire [`DPM_NPINS-1:0] pad_oe_o,
   input wire [`DPM_NODE_W-1:0] node_i,
   output reg gclk_o,
   output reg [`DPM_NPINS-1:0] user_in_o,
   input wire [`DPM_ADDR_W-1:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o
);
   wire [`DPM_NPINS-1:0] pad_s;
   wire mode_s;
   reg [`DPM_NPINS-1:0] used_q;
   reg clkio_q;
   reg [`DPM_CFG_W*`DPM_NPINS-1:0] cfg_q;
   reg [`DPM_NPINS-1:0] udata_q;
   reg [`DPM_NPINS-1:0] uoe_q;
   reg fuse_q;
   reg [`DPM_SHIFT_W-1:0] sel_q;
   reg diag_clock_in_prev_q;
   reg [`DPM_NPINS-1:0] mux_o;
   reg [`DPM_NPINS-1:0] mux_oe;
   reg [`DPM_NPINS-1:0] byp;
   reg diag_q;
   wire diag_on;
   wire diag_clock_in_rise;
   wire [`DPM_NPINS-1:0] buf_o;
   wire [`DPM_NPINS-1:0] buf_oe;
   reg [`DPM_NPINS-1:0] pad_q;
   reg [`DPM_NPINS-1:0] pad_oe_q;

   dpm_sync #(.W(`DPM_NPINS + 1)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .en_i(clk_en_i),
      .d_i({mode_i, pad_i}),
      .q_o({mode_s, pad_s})
   );

   // Node picked by a select field
   function pick;
      input [`DPM_NODE_W-1:0] nodes;
      input [`DPM_SEL_W-1:0] sel;
      begin
         pick = nodes[sel];
      end
   endfunction

   assign diag_on = mode_s & ~fuse_q;
   assign diag_clock_in_rise = pad_s[`DPM_PIN_DIAG_CLOCK_IN] & ~diag_clock_in_prev_q;

   // Register writes and diagnostic shift
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         used_q <= {`DPM_NPINS{1'b0}};
         clkio_q <= 1'b0;
         cfg_q <= {`DPM_CFG_W*`DPM_NPINS{1'b0}};
         udata_q <= {`DPM_NPINS{1'b0}};
         uoe_q <= {`DPM_NPINS{1'b0}};
         fuse_q <= 1'b0;
         sel_q <= {`DPM_SHIFT_W{1'b0}};
         diag_clock_in_prev_q <= 1'b0;
         diag_q <= 1'b0;
      end else if (clk_en_i) begin
         diag_clock_in_prev_q <= pad_s[`DPM_PIN_DIAG_CLOCK_IN];
         diag_q <= diag_on;
         if (wr_i) begin
            case (addr_i)
               `DPM_REG_CTRL: begin
                  used_q <= wdata_i[`DPM_CTRL_USED_LSB +: `DPM_NPINS];
                  clkio_q <= wdata_i[`DPM_CTRL_CLKIO];
               end
               `DPM_REG_CFG: cfg_q <= wdata_i[`DPM_CFG_W*`DPM_NPINS-1:0];
               `DPM_REG_UDATA: udata_q <= wdata_i[`DPM_NPINS-1:0];
               `DPM_REG_UOE: uoe_q <= wdata_i[`DPM_NPINS-1:0];
               `DPM_REG_FUSE: begin
                  if (wdata_i == `DPM_FUSE_KEY) begin
                     fuse_q <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
         if (diag_on && diag_clock_in_rise) begin
            sel_q <= {sel_q[`DPM_SHIFT_W-2:0], pad_s[`DPM_PIN_SDI]};
         end
      end
   end

   generate
      genvar gi;
      for (gi = 0; gi < `DPM_NPINS; gi = gi + 1) begin : g_buf
         // same buffer for every user pin
         dpm_iobuf u_buf (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .en_i(clk_en_i),
            .used_i(used_q[gi]),
            .cfg_i(cfg_q[`DPM_CFG_W*gi +: `DPM_CFG_W]),
            .dout_i(udata_q[gi]),
            .oe_i(uoe_q[gi]),
            .pad_o(buf_o[gi]),
            .pad_oe_o(buf_oe[gi])
         );
      end
   endgenerate

   always @* begin
      mux_o = buf_o;
      mux_oe = buf_oe;
      byp = {`DPM_NPINS{1'b0}};
      if (diag_q) begin
         // diagnostic roles; clock and serial pins become inputs
         mux_oe[`DPM_PIN_DIAG_CLOCK_IN] = 1'b0;
         mux_oe[`DPM_PIN_SDI] = 1'b0;
         mux_o[`DPM_PIN_PRA] = pick(node_i, sel_q[`DPM_SEL_A_LSB +: `DPM_SEL_W]);
         mux_o[`DPM_PIN_PRB] = pick(node_i, sel_q[`DPM_SEL_B_LSB +: `DPM_SEL_W]);
         mux_oe[`DPM_PIN_PRA] = 1'b1;
         mux_oe[`DPM_PIN_PRB] = 1'b1;
         byp[`DPM_PIN_DIAG_CLOCK_IN] = 1'b1;
         byp[`DPM_PIN_SDI] = 1'b1;
         byp[`DPM_PIN_PRA] = 1'b1;
         byp[`DPM_PIN_PRB] = 1'b1;
      end
      if (!clkio_q) begin
         // Clock pin kept as input when it clocks the array
         mux_oe[`DPM_PIN_CLK] = 1'b0;
         byp[`DPM_PIN_CLK] = 1'b1;
      end
   end

   // Pad drive and buffered clock, all registered; probes lag node by one cycle
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pad_q <= {`DPM_NPINS{1'b0}};
         pad_oe_q <= {`DPM_NPINS{1'b0}};
         gclk_o <= 1'b0;
         user_in_o <= {`DPM_NPINS{1'b0}};
      end else if (clk_en_i) begin
         pad_q <= mux_o;
         pad_oe_q <= mux_oe;
         gclk_o <= clkio_q ? 1'b0 : pad_s[`DPM_PIN_CLK];
         user_in_o <= pad_s & ~byp;
      end
   end

   assign pad_o = pad_q;
   assign pad_oe_o = pad_oe_q;

   // Read port, data one cycle after strobe
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h00000000;
      end else if (clk_en_i) begin
         rdata_o <= 32'h00000000;
         if (rd_i) begin
            case (addr_i)
               `DPM_REG_CTRL: rdata_o <= {26'h0, clkio_q, used_q};
               `DPM_REG_CFG: rdata_o <= {22'h0, cfg_q};
               `DPM_REG_UDATA: rdata_o <= {27'h0, udata_q};
               `DPM_REG_UOE: rdata_o <= {27'h0, uoe_q};
               `DPM_REG_STAT: rdata_o <= {29'h0, fuse_q, diag_q, mode_s};
               `DPM_REG_SEL: rdata_o <= {26'h0, sel_q};
               `DPM_REG_UIN: rdata_o <= {27'h0, pad_s};
               `DPM_REG_FUSE: rdata_o <= {31'h0, fuse_q};
               default: rdata_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/dpm_consts.vh
// Constants for the diagnostic pin mode mux
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH
// Node select field widths
`define DPM_NODE_W 8
`define DPM_SEL_W 3
`define DPM_SEL_A_LSB 0
`define DPM_SEL_B_LSB 3
`define DPM_SHIFT_W 6
// Pin configuration codes per user I/O
`define DPM_CFG_W 2
`define DPM_CFG_IN 2'h0
`define DPM_CFG_OUT 2'h1
`define DPM_CFG_TRI 2'h2
`define DPM_CFG_BIDIR 2'h3
// Register indices
`define DPM_ADDR_W 4
`define DPM_REG_CTRL 4'h0
`define DPM_REG_CFG 4'h1
`define DPM_REG_UDATA 4'h2
`define DPM_REG_UOE 4'h3
`define DPM_REG_STAT 4'h4
`define DPM_REG_SEL 4'h5
`define DPM_REG_UIN 4'h6
`define DPM_REG_FUSE 4'h7
// Control bit positions
`define DPM_CTRL_USED_LSB 0
`define DPM_CTRL_CLKIO 5
// Fuse key that must be written to blow the probe fuse
`define DPM_FUSE_KEY 32'h00000a5a
// Multifunction pin count plus clock pin
`define DPM_NPINS 5
`define DPM_PIN_DIAG_CLOCK_IN 0
`define DPM_PIN_SDI 1
`define DPM_PIN_PRA 2
`define DPM_PIN_PRB 3
`define DPM_PIN_CLK 4
`endif

// file: logic/dpm_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dpm_sync #(
   parameter W = 1
) (
   input wire sys_clk_i,
   input wire rst_i,
   input wire en_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta_q;
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= {W{1'b0}};
         q_o <= {W{1'b0}};
      end else if (en_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: logic/dpm_iobuf.v
// One configurable user I/O buffer
`include "dpm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module dpm_iobuf (
   input wire sys_clk_i,
   input wire rst_i,
   input wire en_i,
   input wire used_i,
   input wire [`DPM_CFG_W-1:0] cfg_i,
   input wire dout_i,
   input wire oe_i,
   output reg pad_o,
   output reg pad_oe_o
);
   reg o_d;
   reg oe_d;
   always @* begin
      o_d = 1'b0;
      oe_d = 1'b0;
      if (!used_i) begin
         oe_d = 1'b1;
      end else begin
         case (cfg_i)
            `DPM_CFG_IN: oe_d = 1'b0;
            `DPM_CFG_OUT: begin
               o_d = dout_i;
               oe_d = 1'b1;
            end
            `DPM_CFG_TRI, `DPM_CFG_BIDIR: begin
               o_d = dout_i;
               oe_d = oe_i;
            end
            default: oe_d = 1'b0;
         endcase
      end
   end
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pad_o <= 1'b0;
         pad_oe_o <= 1'b1;
      end else if (en_i) begin
         pad_o <= o_d;
         pad_oe_o <= oe_d;
      end
   end
endmodule
`default_nettype wire

// file: bench/dpm_monitor.sv
// Port checker for the diagnostic pin mode mux
`timescale 1ns/1ps
`default_nettype none
module dpm_monitor (
   input wire sys_clk_i,
   input wire rst_i,
   input wire clk_en_i,
   input wire mode_i,
   input wire [4:0] pad_i,
   input wire [4:0] pad_o,
   input wire [4:0] pad_oe_o,
   input wire gclk_o,
   input wire [4:0] user_in_o,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o
);
   // Shadows of the write-only effects the ports cannot show
   reg fuse_q, u0_q, clkio_q;
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fuse_q <= 1'b0;
         u0_q <= 1'b0;
         clkio_q <= 1'b0;
      end else if (clk_en_i && wr_i) begin
         if (addr_i == 4'h7 && wdata_i == 32'h00000a5a) begin
            fuse_q <= 1'b1;
         end
         if (addr_i == 4'h0) begin
            u0_q <= wdata_i[0];
            clkio_q <= wdata_i[5];
         end
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Frozen clock enable holds the last read word
   a_rdata_idle: assert property ($past(clk_en_i) && !$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   a_diag_probe_oe: assert property (mode_i[*8] ##0 !fuse_q |-> pad_oe_o[3:2] == 2'h3)
      else $error("probe pins not driven in diagnostic mode");
   a_diag_no_user: assert property (mode_i[*8] ##0 !fuse_q |-> user_in_o[3:0] == 4'h0)
      else $error("diagnostic pins leak to user logic");
   a_fuse_status: assert property (rd_i && addr_i == 4'h4 && fuse_q |=> rdata_o[2])
      else $error("fuse not reported");
   a_fuse_read: assert property (rd_i && addr_i == 4'h7 |=> rdata_o[0] == $past(fuse_q))
      else $error("fuse register wrong");
   a_unused_low: assert property ((!mode_i)[*8] ##0 (!u0_q)[*4] |-> pad_oe_o[0] && !pad_o[0])
      else $error("unused pin not driven low");
   a_clkio_no_gclk: assert property (clkio_q[*4] |-> !gclk_o)
      else $error("clock runs while pin is user I/O");
   a_clk_no_user: assert property ((!clkio_q)[*4] |-> !user_in_o[4])
      else $error("clock pin leaks to user logic");
   // Clock role must hold over the whole window, not just its start
   a_gclk_follow: assert property ((!clkio_q && pad_i[4])[*5] |-> gclk_o)
      else $error("global clock does not follow pin");
endmodule
bind dpm_pin_mux dpm_monitor u_mon (.sys_clk_i, .rst_i, .clk_en_i, .mode_i, .pad_i, .pad_o,
   .pad_oe_o, .gclk_o, .user_in_o, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
`default_nettype wire

// file: bench/dpm_diag_host.sv
// Behavioural diagnostic equipment on the diag clock and serial pins
`timescale 1ns/1ps
`default_nettype none
module dpm_diag_host (
   output var logic diag_clock_in_o,
   output var logic sdi_o
);
   initial begin
      diag_clock_in_o = 1'b0;
      sdi_o = 1'b0;
   end
   task send(input logic [5:0] bits);
      integer i;
      for (i = 5; i >= 0; i = i - 1) begin
         sdi_o = bits[i];
         #40 diag_clock_in_o = 1'b1;
         #80 diag_clock_in_o = 1'b0;
         #40;
      end
      // Released line must not keep a stale level
      sdi_o = ~bits[0];
   endtask
endmodule
`default_nettype wire

// file: bench/dpm_pin_mux_tb.sv
// Self-checking bench for the diagnostic pin mode mux
`timescale 1ns/1ps
`default_nettype none
module dpm_pin_mux_tb;
   logic sys_clk_i, rst_i, clk_en_i, mode_i, wr_i, rd_i, gclk_o;
   logic [2:0] pad_hi;
   logic [7:0] node_i;
   logic [3:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [4:0] pad_o, pad_oe_o, user_in_o;
   wire diag_clock_in, diag_serial_in;
   integer err_count, checks_done;
   dpm_diag_host host (.diag_clock_in_o(diag_clock_in), .sdi_o(diag_serial_in));
   dpm_pin_mux dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .mode_i(mode_i),
      .pad_i({pad_hi, diag_serial_in, diag_clock_in}), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .node_i(node_i),
      .gclk_o(gclk_o), .user_in_o(user_in_o), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] exp, input string n);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk(n, rdata_o, exp);
   endtask
   task idle(input integer c);
      repeat (c) @(posedge sys_clk_i);
      #1;
   endtask
   task final_report;
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000 err_count = err_count + 1;
      final_report;
   end
   initial begin
      err_count = 0;
      checks_done = 0;
      clk_en_i = 1'b1;
      {rst_i, mode_i, wr_i, rd_i, addr_i, wdata_i, node_i, pad_hi} = {1'b1, 50'h0};
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      idle(6);
      chk("unused pins", {pad_oe_o[3:0], pad_o[3:0]}, 8'hf0);
      rd(4'h9, 32'h0, "unmapped");
      $display("Test reset done");
      // Pin 0 input, 1 output, 2 three-state, 3 bidir, 4 output
      wr(4'h1, 32'h1e4);
      wr(4'h2, 32'h1f);
      wr(4'h3, 32'h4);
      wr(4'h0, 32'hf);
      pad_hi <= 3'h2;
      idle(6);
      chk("user pins", {pad_oe_o[3:0], pad_o[2:1]}, 6'h1b);
      chk("bidir in", user_in_o[3], 1'b1);
      rd(4'h1, 32'h1e4, "cfg read");
      rd(4'h3, 32'h4, "oe read");
      rd(4'h6, 32'h8, "raw pads");
      pad_hi <= 3'h6;
      idle(6);
      chk("clk role", {gclk_o, user_in_o[4]}, 2'h2);
      wr(4'h0, 32'h3f);
      idle(6);
      chk("clk as io", {pad_oe_o[4], pad_o[4], gclk_o}, 3'h6);
      chk("clk pin in", user_in_o[4], 1'b1);
      rd(4'h0, 32'h3f, "ctrl read");
      idle(2);
      // Write under a low clock enable must not land
      clk_en_i <= 1'b0;
      wr(4'h2, 32'h0);
      clk_en_i <= 1'b1;
      rd(4'h2, 32'h1f, "write frozen");
      $display("Test user io done");
      mode_i <= 1'b1;
      idle(8);
      host.send(6'h2b);
      idle(8);
      rd(4'h5, 32'h2b, "select");
      rd(4'h4, 32'h3, "status");
      chk("diag in pins", pad_oe_o[1:0], 2'h0);
      node_i <= 8'h08;
      idle(4);
      chk("probe a", {pad_oe_o[3:2], pad_o[3:2]}, 4'hd);
      node_i <= 8'h20;
      idle(4);
      chk("probe b", {pad_oe_o[3:2], pad_o[3:2]}, 4'he);
      mode_i <= 1'b0;
      idle(8);
      host.send(6'h0);
      idle(8);
      rd(4'h5, 32'h2b, "select kept");
      chk("probe reuse", {pad_oe_o[3:2], pad_o[2]}, 3'h3);
      $display("Test diag done");
      wr(4'h7, 32'ha55);
      rd(4'h7, 32'h0, "bad key");
      wr(4'h7, 32'ha5a);
      rd(4'h7, 32'h1, "fuse");
      mode_i <= 1'b1;
      idle(8);
      host.send(6'h3f);
      idle(8);
      rd(4'h5, 32'h2b, "select locked");
      rd(4'h4, 32'h5, "status locked");
      chk("probes off", pad_oe_o[3:2], 2'h1);
      $display("Test fuse done");
      final_report;
   end
endmodule
`default_nettype wire
